/* File: rtl/elrb_pkg.sv */
// Constants for the event log record builder.
// Assumes a single 100 MHz core clock and a word-wide register port.
package elrb_pkg;

	// Register word indices (byte address = 4 * index)
	localparam logic [7:0] ELRB_REG_CTRL    = 8'h00;
	localparam logic [7:0] ELRB_REG_STATUS  = 8'h01;
	localparam logic [7:0] ELRB_REG_IRQ_ST  = 8'h02;
	localparam logic [7:0] ELRB_REG_IRQ_MSK = 8'h03;
	localparam logic [7:0] ELRB_REG_REC_LEN = 8'h04;
	localparam logic [7:0] ELRB_REG_HDR     = 8'h05;
	localparam logic [7:0] ELRB_REG_BUF     = 8'h40;
	localparam logic [7:0] ELRB_REG_BUF_END = 8'h53;

	// Control register fields
	localparam int ELRB_CTRL_AER_SUP    = 0;
	localparam int ELRB_CTRL_HDRLOG_SUP = 1;
	localparam int ELRB_CTRL_PFXLOG_SUP = 2;
	localparam int ELRB_CTRL_GROUP_SUP  = 3;
	localparam logic [3:0] ELRB_CTRL_RESET = 4'h0;

	// Interrupt status bits
	localparam int ELRB_IRQ_ERR_REC = 0;
	localparam int ELRB_IRQ_NS_REC  = 1;

	// Record geometry
	localparam int ELRB_ERR_WORDS  = 20;
	localparam int ELRB_NS_WORDS   = 12;
	localparam logic [7:0] ELRB_ERR_BYTES = 8'h50;
	localparam logic [7:0] ELRB_NS_BYTES  = 8'h30;

	// Change-namespace header codes
	localparam logic [7:0] ELRB_NS_EVENT_TYPE = 8'h06;
	localparam logic [7:0] ELRB_NS_EVENT_REV  = 8'h01;

	// Record kind codes and the all-namespaces identifier
	localparam logic [1:0] ELRB_KIND_NONE = 2'h0;
	localparam logic [1:0] ELRB_KIND_ERR  = 2'h1;
	localparam logic [1:0] ELRB_KIND_NS   = 2'h2;
	localparam logic [31:0] ELRB_NAMESPACE_IDENTIFIER_ALL = 32'hffffffff;

	typedef enum logic [1:0]
	{
		ELRB_IDLE  = 2'b00,
		ELRB_BUILD = 2'b01,
		ELRB_DONE  = 2'b11
	} elrb_state_type;

endpackage

/* File: rtl/elrb_builder.sv */
// Event log record builder: assembles link error and change-namespace records.
// Assumes event strobes are single-cycle pulses from logic on clk.
//
// What this block does
// RQ1: Device status snapshot in error bytes 1:0
// RQ2: Byte 2 bit 0 shows AER support
// RQ3: Status snapshot by error class, bytes 31:16
// RQ4: Mask snapshot by error class, bytes 47:32
// RQ5: Header log in bytes 63:48 if supported
// RQ6: Prefix log in bytes 79:64 if supported
// RQ7: Namespace record only after successful command
// RQ8: Header carries type 06h, revision 01h
// RQ9: Command dword ten in bytes 3:0
// RQ10: Namespace size in bytes 15:8
// RQ11: Namespace capacity in bytes 31:24
// RQ12: Block size selector in byte 32
// RQ13: Protection settings in byte 33
// RQ14: Multipath sharing byte 34, byte 35 reserved
// RQ15: Delete-all makes namespace fields reserved
// RQ16: All reserved bits filled with zero
// RQ17: Group id bytes 39:36, zero if unsupported
// RQ18: Set id in bytes 41:40
// RQ19: Namespace identifier in bytes 47:44
//
// The address map and strobed register access were left to the implementer.
module elrb_builder
	import elrb_pkg::*;
(
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         err_event,
	input  wire logic         err_uncorrectable,
	input  wire logic [15:0]  dev_status,
	input  wire logic [127:0] corr_status,
	input  wire logic [127:0] uncorr_status,
	input  wire logic [127:0] corr_mask,
	input  wire logic [127:0] uncorr_mask,
	input  wire logic [127:0] header_log,
	input  wire logic [127:0] prefix_log,
	input  wire logic         ns_event,
	input  wire logic         ns_success,
	input  wire logic         ns_delete,
	input  wire logic [31:0]  command_dword_ten,
	input  wire logic [31:0]  namespace_identifier,
	input  wire logic [63:0]  cmd_namespace_size,
	input  wire logic [63:0]  cmd_namespace_capacity,
	input  wire logic [7:0]   cmd_formatted_block_size_sel,
	input  wire logic [7:0]   cmd_protection_type_settings,
	input  wire logic [7:0]   cmd_multipath_sharing_caps,
	input  wire logic [31:0]  cmd_access_group_id,
	input  wire logic [15:0]  cmd_storage_set_id,
	input  wire logic [63:0]  del_namespace_size,
	input  wire logic [63:0]  del_namespace_capacity,
	input  wire logic [7:0]   del_formatted_block_size_sel,
	input  wire logic [7:0]   del_protection_type_settings,
	input  wire logic [7:0]   del_multipath_sharing_caps,
	input  wire logic [31:0]  del_access_group_id,
	input  wire logic [15:0]  del_storage_set_id,
	input  wire logic [7:0]   reg_addr,
	input  wire logic [31:0]  reg_wdata,
	input  wire logic         reg_write,
	input  wire logic         reg_read,
	output logic [31:0]       reg_rdata,
	output logic              record_ready,
	output logic              irq
);

	////////////////////////////////////////////////////////////////////////////////
	// State

	logic [31:0]    rec_buf [ELRB_ERR_WORDS];
	logic [31:0]    next_buf [ELRB_ERR_WORDS];
	logic [1:0]     kind;
	logic [1:0]     next_kind;
	logic [3:0]     ctrl;
	logic [3:0]     next_ctrl;
	logic [1:0]     irq_st;
	logic [1:0]     next_irq_st;
	logic [1:0]     irq_msk;
	logic [1:0]     next_irq_msk;
	logic [31:0]    next_rdata;
	logic           next_irq;
	elrb_state_type state;
	elrb_state_type next_state;

	// Assembled images; built combinationally from the live inputs so the
	// snapshot is exactly what the sources held in the event cycle.
	logic [639:0]   err_img;
	logic [383:0]   ns_img;
	logic           take_err;
	logic           take_ns;
	logic           del_all;
	logic [7:0]     widx;

	////////////////////////////////////////////////////////////////////////////////
	// Record assembly

	always_comb
	begin
		err_img = '0;                                                       // [RQ16]
		err_img[15:0] = dev_status;                                         // [RQ1]
		err_img[16] = ctrl[ELRB_CTRL_AER_SUP];                              // [RQ2]
		err_img[255:128] = err_uncorrectable ? uncorr_status : corr_status; // [RQ3]
		err_img[383:256] = err_uncorrectable ? uncorr_mask : corr_mask;     // [RQ4]
		if (ctrl[ELRB_CTRL_HDRLOG_SUP])
		begin
			err_img[511:384] = header_log;                                  // [RQ5]
		end
		if (ctrl[ELRB_CTRL_PFXLOG_SUP])
		begin
			err_img[639:512] = prefix_log;                                  // [RQ6]
		end
	end

	always_comb
	begin
		del_all = ns_delete && (namespace_identifier == ELRB_NAMESPACE_IDENTIFIER_ALL);
		ns_img = '0;                                                        // [RQ16]
		ns_img[31:0] = command_dword_ten;                                   // [RQ9]
		if (!del_all)                                                       // [RQ15]
		begin
			ns_img[127:64]  = ns_delete ? del_namespace_size
				: cmd_namespace_size;                                       // [RQ10]
			ns_img[255:192] = ns_delete ? del_namespace_capacity
				: cmd_namespace_capacity;                                   // [RQ11]
			ns_img[263:256] = ns_delete ? del_formatted_block_size_sel
				: cmd_formatted_block_size_sel;                             // [RQ12]
			ns_img[271:264] = ns_delete ? del_protection_type_settings
				: cmd_protection_type_settings;                             // [RQ13]
			ns_img[279:272] = ns_delete ? del_multipath_sharing_caps
				: cmd_multipath_sharing_caps;                               // [RQ14]
			if (ctrl[ELRB_CTRL_GROUP_SUP])
			begin
				ns_img[319:288] = ns_delete ? del_access_group_id
					: cmd_access_group_id;                                  // [RQ17]
			end
			ns_img[335:320] = ns_delete ? del_storage_set_id
				: cmd_storage_set_id;                                       // [RQ18]
		end
		ns_img[383:352] = namespace_identifier;                             // [RQ19]
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sequencing: an error event wins over a namespace event in the same cycle

	always_comb
	begin
		take_err = err_event;
		take_ns = ns_event && ns_success && !err_event;                     // [RQ7]
		next_state = state;
		next_kind = kind;
		for (int i = 0; i < ELRB_ERR_WORDS; i++)
		begin
			next_buf[i] = rec_buf[i];
		end
		case (state)
			ELRB_IDLE,
			ELRB_DONE:
			begin
				if (take_err || take_ns)
				begin
					next_state = ELRB_BUILD;
				end
			end
			ELRB_BUILD:
			begin
				next_state = ELRB_DONE;
			end
			default:
			begin
				next_state = ELRB_IDLE;
			end
		endcase
		if (take_err)
		begin
			next_kind = ELRB_KIND_ERR;
			for (int i = 0; i < ELRB_ERR_WORDS; i++)
			begin
				next_buf[i] = err_img[i*32 +: 32];
			end
		end
		else if (take_ns)
		begin
			next_kind = ELRB_KIND_NS;
			for (int i = 0; i < ELRB_ERR_WORDS; i++)
			begin
				next_buf[i] = (i < ELRB_NS_WORDS) ? ns_img[i*32 +: 32] : 32'h00000000;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register port and interrupt

	always_comb
	begin
		widx = reg_addr - ELRB_REG_BUF;
		next_ctrl = ctrl;
		next_irq_msk = irq_msk;
		next_irq_st = irq_st;
		next_rdata = 32'h00000000;
		if (reg_write && reg_addr == ELRB_REG_CTRL)
		begin
			next_ctrl = reg_wdata[3:0];
		end
		if (reg_write && reg_addr == ELRB_REG_IRQ_MSK)
		begin
			next_irq_msk = reg_wdata[1:0];
		end
		if (reg_read)
		begin
			if (reg_addr == ELRB_REG_CTRL)
			begin
				next_rdata = {28'h0000000, ctrl};
			end
			else if (reg_addr == ELRB_REG_STATUS)
			begin
				next_rdata = {28'h0000000, kind, state};
			end
			else if (reg_addr == ELRB_REG_IRQ_ST)
			begin
				next_rdata = {30'h00000000, irq_st};
				next_irq_st = 2'h0;
			end
			else if (reg_addr == ELRB_REG_IRQ_MSK)
			begin
				next_rdata = {30'h00000000, irq_msk};
			end
			else if (reg_addr == ELRB_REG_REC_LEN)
			begin
				next_rdata = {24'h000000, (kind == ELRB_KIND_ERR) ? ELRB_ERR_BYTES
					: (kind == ELRB_KIND_NS) ? ELRB_NS_BYTES : 8'h00};
			end
			else if (reg_addr == ELRB_REG_HDR)
			begin
				next_rdata = (kind == ELRB_KIND_NS)
					? {16'h0000, ELRB_NS_EVENT_REV, ELRB_NS_EVENT_TYPE} // [RQ8]
					: 32'h00000000;
			end
			else if (reg_addr >= ELRB_REG_BUF && reg_addr <= ELRB_REG_BUF_END)
			begin
				next_rdata = rec_buf[widx[4:0]];
			end
		end
		// A new event set in the clearing cycle survives the read-clear
		if (take_err)
		begin
			next_irq_st[ELRB_IRQ_ERR_REC] = 1'b1;
		end
		if (take_ns)
		begin
			next_irq_st[ELRB_IRQ_NS_REC] = 1'b1;
		end
		next_irq = |(next_irq_st & irq_msk);
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state <= ELRB_IDLE;
			kind <= ELRB_KIND_NONE;
			ctrl <= ELRB_CTRL_RESET;
			irq_st <= 2'h0;
			irq_msk <= 2'h0;
			reg_rdata <= 32'h00000000;
			record_ready <= 1'b0;
			irq <= 1'b0;
			for (int i = 0; i < ELRB_ERR_WORDS; i++)
			begin
				rec_buf[i] <= 32'h00000000;
			end
		end
		else
		begin
			state <= next_state;
			kind <= next_kind;
			ctrl <= next_ctrl;
			irq_st <= next_irq_st;
			irq_msk <= next_irq_msk;
			reg_rdata <= next_rdata;
			record_ready <= (next_kind != ELRB_KIND_NONE);
			irq <= next_irq;
			for (int i = 0; i < ELRB_ERR_WORDS; i++)
			begin
				rec_buf[i] <= next_buf[i];
			end
		end
	end

endmodule // elrb_builder

/* File: dv/elrb_builder_props.sv */
// Checker: port-level timing of the record builder.
// Assumes one clock domain; bound to every builder instance.
module elrb_builder_props
(
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        err_event,
	input wire logic        ns_event,
	input wire logic        ns_success,
	input wire logic [7:0]  reg_addr,
	input wire logic        reg_read,
	input wire logic [31:0] reg_rdata,
	input wire logic        record_ready,
	input wire logic        irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
		else $error("read data outside read slot");
	a_unmapped_zero: assert property (reg_read && reg_addr == 8'h30 |=> reg_rdata == 32'h0)
		else $error("unmapped read not zero");
	a_err_ready: assert property (err_event |-> ##2 record_ready)
		else $error("no record after error");
	a_ns_ready: assert property (ns_event && ns_success |-> ##2 record_ready)
		else $error("no record after namespace command");
	a_ready_hold: assert property (record_ready |=> record_ready)
		else $error("record ready dropped");
	a_rose_cause: assert property ($rose(record_ready) |->
		$past(err_event) || ($past(ns_event) && $past(ns_success)))
		else $error("record without cause");
	a_irq_ready: assert property (irq |-> record_ready)
		else $error("irq without record");
	// Holds only while no event lands beside the read
	a_irq_clear: assert property (reg_read && reg_addr == 8'h02 && !err_event && !ns_event
		|-> ##[1:2] !irq)
		else $error("irq kept after status read");
endmodule // elrb_builder_props

bind elrb_builder elrb_builder_props elrb_builder_props_inst
(
	.clk(clk), .rst(rst), .err_event(err_event), .ns_event(ns_event),
	.ns_success(ns_success), .reg_addr(reg_addr), .reg_read(reg_read),
	.reg_rdata(reg_rdata), .record_ready(record_ready), .irq(irq)
);

/* File: dv/elrb_host_model.sv */
// Host model: software reading finished records over the register port.
// Assumes clk from the bench; strobes change right after rising edges.
module elrb_host_model
(
	input  wire logic [31:0] reg_rdata,
	input  wire logic        clk,
	output logic      [7:0]  reg_addr = 8'h0,
	output logic      [31:0] reg_wdata = 32'h0,
	output logic             reg_write = 1'b0,
	output logic             reg_read = 1'b0
);
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask
	// Data is valid only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		// Sample mid-cycle, clear of the edge that launches the data
		@(negedge clk);
		d = reg_rdata;
	endtask
endmodule // elrb_host_model

/* File: dv/elrb_builder_tb_top.sv */
// Bench: raises events and reads records back through the host model.
// Assumes the checker bind is compiled with the builder.
module elrb_builder_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst = 1, err_event = 0, err_uncorrectable = 0, ns_event = 0;
	logic ns_success = 0, ns_delete = 0, reg_write, reg_read, record_ready, irq;
	logic [7:0] reg_addr;
	logic [15:0] dev_status = 16'hb00c, cmd_storage_set_id = 16'h0a0b;
	logic [15:0] del_storage_set_id = 16'h0c0d;
	logic [127:0] corr_status = {4{32'hc5c5_0001}}, uncorr_status = {4{32'h05a5_0002}};
	logic [127:0] corr_mask = {4{32'hc3c3_0003}}, uncorr_mask = {4{32'h0303_0004}};
	logic [127:0] header_log = {4{32'h4e4e_0005}}, prefix_log = {4{32'h9f9f_0006}};
	logic [31:0] command_dword_ten = 32'h1234_5678, namespace_identifier = 32'h0;
	logic [31:0] cmd_access_group_id = 32'h77, del_access_group_id = 32'h88;
	logic [31:0] reg_wdata, reg_rdata;
	logic [63:0] cmd_namespace_size = 64'h11, cmd_namespace_capacity = 64'h22;
	logic [63:0] del_namespace_size = 64'h33, del_namespace_capacity = 64'h44;
	logic [7:0] cmd_formatted_block_size_sel = 8'h01, del_formatted_block_size_sel = 8'h0a;
	logic [7:0] cmd_protection_type_settings = 8'h02, del_protection_type_settings = 8'h0b;
	logic [7:0] cmd_multipath_sharing_caps = 8'h03, del_multipath_sharing_caps = 8'h0c;
	int checks = 0, mismatches = 0;
	elrb_builder elrb_builder_inst (.*);
	elrb_host_model elrb_host_model_inst (.clk(clk), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata));
	always #5 clk = ~clk;
	////////////////////////////////////////////////////////////////
	task automatic stop_test;
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] e, g);
		checks++;
		if (e !== g)
		begin
			mismatches++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		elrb_host_model_inst.rd(a, d);
		chk(e, d);
	endtask
	// Whole buffer is read, so stale words of a longer record show up
	task automatic rec(input logic [639:0] e, input logic [7:0] len);
		for (int i = 0; i < 20; i++)
			rc(8'h40 + 8'(i), e[32*i +: 32]);
		rc(8'h04, {24'h0, len});
	endtask
	function automatic logic [639:0] nsr(logic [63:0] sz, cp, logic [23:0] b,
		logic [31:0] g, logic [15:0] s, logic [31:0] id);
		return {256'h0, id, 16'h0, s, g, 8'h0, b, cp, 64'h0, sz, 32'h0, command_dword_ten};
	endfunction
	task automatic ev(input logic e, s, d, input logic [31:0] id);
		@(posedge clk);
		err_event <= e;
		err_uncorrectable <= d;
		ns_event <= !e;
		ns_success <= s;
		ns_delete <= d;
		namespace_identifier <= id;
		@(posedge clk);
		err_event <= 1'b0;
		ns_event <= 1'b0;
	endtask
	initial
	begin
		#50us;
		mismatches++;
		stop_test();
	end
	initial
	begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk(32'h0, {31'h0, record_ready});
		elrb_host_model_inst.wr(8'h03, 32'h3);
		elrb_host_model_inst.wr(8'h00, 32'h7);
		ev(1, 0, 1, 0);
		rec({prefix_log, header_log, uncorr_mask, uncorr_status, 104'h0, 8'h01, dev_status},
			8'h50);
		chk(32'h1, {31'h0, irq});
		chk(32'h1, {31'h0, record_ready});
		rc(8'h02, 32'h1);
		chk(32'h0, {31'h0, irq});
		rc(8'h30, 32'h0);
		elrb_host_model_inst.wr(8'h00, 32'h8);
		ev(1, 0, 0, 0);
		rec({256'h0, corr_mask, corr_status, 112'h0, dev_status}, 8'h50);
		ev(0, 1, 0, 32'h5);
		rec(nsr(cmd_namespace_size, cmd_namespace_capacity, 24'h030201,
			cmd_access_group_id, cmd_storage_set_id, 32'h5), 8'h30);
		rc(8'h05, 32'h0000_0106);
		rc(8'h01, 32'h0000_000b);
		rc(8'h02, 32'h3);
		ev(0, 0, 1, 32'h9);
		rec(nsr(cmd_namespace_size, cmd_namespace_capacity, 24'h030201,
			cmd_access_group_id, cmd_storage_set_id, 32'h5), 8'h30);
		elrb_host_model_inst.wr(8'h00, 32'h0);
		ev(0, 1, 1, 32'h9);
		rec(nsr(del_namespace_size, del_namespace_capacity, 24'h0c0b0a,
			32'h0, del_storage_set_id, 32'h9), 8'h30);
		ev(0, 1, 1, 32'hffff_ffff);
		rec(nsr(0, 0, 0, 0, 0, 32'hffff_ffff), 8'h30);
		stop_test();
	end
endmodule // elrb_builder_tb_top
